// >>> inc/dad_pkg.sv
// Constants and register map of the drive assist, display and fault log block.
// Notes on behaviour
// - Reverse prevention set ignores reverse run commands.
// - Keypad edits apply on enter, or immediately.
// - Carrier mode picks one of five schemes.
// - Dual random mode drops a third of switchings.
// - Second accel/decel times, chosen by multifunction input.
// - Four S-curve times, 0.0 to 4.0 s.
// - Ramp duration is ramp time plus S-curve time.
// - Zero S-curve time gives a linear ramp.
// - S-curve referenced to motor rated frequency.
// - Output frequency avoids three skip bands.
// - Above 80 C drop carrier 4 kHz; below 70 resume.
// - Five display enable digits, one bit each.
// - Line speed scales with output frequency.
// - Line display mode: frequency or 0..3 decimals.
// - Line speed shown while running and stopped.
// - PID feedback maps linearly between min and max.
// - PID format: integer, one or two decimals.
// - PID unit: none, pressure or flow suffix.
// - New fault shifts history, stored as latest.
// - Viewing starts at latest; up/down step cyclically.
// - Reset while viewing clears all three entries.
package dad_pkg;
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_ACC2       = 8'h04;
    localparam logic [7:0]  ADDR_DEC2       = 8'h08;
    localparam logic [7:0]  ADDR_SCURVE     = 8'h0C;
    localparam logic [7:0]  ADDR_SKIP1      = 8'h10;
    localparam logic [7:0]  ADDR_SKIP2      = 8'h14;
    localparam logic [7:0]  ADDR_SKIP3      = 8'h18;
    localparam logic [7:0]  ADDR_SKIP_RANGE = 8'h1C;
    localparam logic [7:0]  ADDR_LINE_SPEED = 8'h20;
    localparam logic [7:0]  ADDR_RATED_FREQ = 8'h24;
    localparam logic [7:0]  ADDR_PID_SPAN   = 8'h28;
    localparam logic [7:0]  ADDR_STATUS     = 8'h2C;
    localparam logic [7:0]  ADDR_FAULT_LOG  = 8'h30;
    localparam logic [7:0]  ADDR_DISPLAY    = 8'h34;
    // Control register field positions.
    localparam int CTRL_REV_BLOCK  = 0;
    localparam int CTRL_UPDN_DIRECT = 1;
    localparam int CTRL_DERATE_EN  = 2;
    localparam int CTRL_CARRIER_LO = 4;
    localparam int CTRL_MODE_LO    = 8;
    localparam int CTRL_DISP_LO    = 11;
    localparam int CTRL_LINE_LO    = 16;
    localparam int CTRL_PIDFMT_LO  = 19;
    localparam int CTRL_PIDUNIT_LO = 21;
    localparam int PID_MIN_LO      = 16;
    // Reset values.
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0050;
    localparam logic [15:0] ACC2_RESET       = 16'h0064;
    localparam logic [15:0] DEC2_RESET       = 16'h0064;
    localparam logic [15:0] RATED_FREQ_RESET = 16'h1770;
    localparam logic [15:0] LINE_SPEED_RESET = 16'h0708;
    localparam logic [9:0]  PID_MAX_RESET    = 10'h3E7;
    // Limits, in the units of each register.
    localparam logic [15:0] ACC_MIN      = 16'h0001;
    localparam logic [15:0] ACC_MAX      = 16'h8CA0;
    localparam logic [5:0]  SCURVE_MAX   = 6'h28;
    localparam logic [15:0] FREQ_MAX     = 16'h9C40;
    localparam logic [15:0] SKIP_RANGE_MAX = 16'h0BB8;
    localparam logic [9:0]  PID_LIMIT    = 10'h3E7;
    localparam logic [15:0] KEY_STEP     = 16'h000A;
    localparam logic [3:0]  CARRIER_MAX  = 4'hF;
    localparam logic [3:0]  DERATE_KHZ   = 4'h4;
    localparam logic [2:0]  MODE_MAX     = 3'h4;
    localparam logic [2:0]  LINE_MODE_MAX = 3'h4;
    localparam logic [1:0]  PID_CODE_MAX = 2'h2;
    // Heatsink thresholds in degrees Celsius.
    localparam logic [7:0]  TEMP_HOT  = 8'h50;
    localparam logic [7:0]  TEMP_COOL = 8'h46;
    // Clock rate and carrier accumulator step.
    localparam int          CLK_HZ     = 25000000;
    localparam logic [24:0] CLK_HZ_W   = 25'(CLK_HZ);
    localparam logic [9:0]  KHZ_STEP   = 10'h3E8;
    localparam logic [1:0]  DUAL_DROP  = 2'h2;
    typedef enum logic [2:0] {
        DAD_THREE_PHASE = 3'h0,
        DAD_TWO_PHASE   = 3'h1,
        DAD_TWO_RANDOM  = 3'h2,
        DAD_RANDOM      = 3'h3,
        DAD_DUAL_RANDOM = 3'h4
    } dad_mode_e;
endpackage

// >>> logic/dad_top.sv
// Drive assist logic: keypad entry, carrier control, ramps, skip bands, display and fault log.
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
module dad_top
    import dad_pkg::*;
(
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Run commands and multifunction input pins.
    input  wire logic        run_fwd_pin,
    input  wire logic        run_rev_pin,
    input  wire logic        multifunction_input_select,
    // Keypad pins.
    input  wire logic        key_up,
    input  wire logic        key_down,
    input  wire logic        key_enter,
    input  wire logic        key_reset,
    input  wire logic        fault_view,
    // Sensors and fault source.
    input  wire logic [7:0]  heatsink_temp,
    input  wire logic [11:0] pid_feedback,
    input  wire logic        fault_trip,
    input  wire logic [7:0]  fault_code,
    // Run and ramp outputs.
    output logic             run_fwd,
    output logic             run_rev,
    output logic [15:0]      freq_out,
    output logic             accdec2_active,
    output logic [15:0]      ramp_acc_total,
    output logic [15:0]      ramp_dec_total,
    output logic [3:0]       scurve_enable,
    output logic [15:0]      scurve_ref_freq,
    // PWM stage outputs.
    output logic [3:0]       carrier_khz,
    output logic [2:0]       carrier_mode,
    output logic             carrier_tick,
    output logic             carrier_derated,
    // Display outputs.
    output logic [4:0]       disp_items,
    output logic [15:0]      disp_value,
    output logic [1:0]       disp_decimals,
    output logic [9:0]       pid_disp,
    output logic [1:0]       pid_decimals,
    output logic [1:0]       pid_unit,
    output logic [1:0]       fault_view_idx,
    output logic [7:0]       fault_view_code
);
    // Pin synchronisers: eight control pins and the temperature byte.
    logic [15:0] pin_raw;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] sync3;
    assign pin_raw = {heatsink_temp, fault_view, key_reset, key_enter, key_down, key_up,
                      multifunction_input_select, run_rev_pin, run_fwd_pin};
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                end
            end
        end
    endgenerate
    logic [7:0] temp_s;
    logic       up_press;
    logic       down_press;
    logic       enter_press;
    logic       reset_press;
    logic       view_s;
    logic       view_enter;
    assign temp_s      = sync2[15:8];
    assign view_s      = sync2[7];
    assign up_press    = sync2[3] & ~sync3[3];
    assign down_press  = sync2[4] & ~sync3[4];
    assign enter_press = sync2[5] & ~sync3[5];
    assign reset_press = sync2[6] & ~sync3[6];
    assign view_enter  = sync2[7] & ~sync3[7];

    // Bus slave: address phase captured, write committed in the data phase.
    logic       dph_valid;
    logic       dph_write;
    logic [7:0] dph_addr;
    logic       next_dph_valid;
    logic       next_dph_write;
    logic [7:0] next_dph_addr;
    always_comb begin
        next_dph_valid = dph_valid;
        next_dph_write = dph_write;
        next_dph_addr  = dph_addr;
        if (hready) begin
            next_dph_valid = hsel & htrans[1];
            next_dph_write = hwrite;
            next_dph_addr  = {haddr[7:2], 2'b00};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_valid <= 1'b0;
            dph_write <= 1'b0;
            dph_addr  <= 8'h00;
        end else begin
            dph_valid <= next_dph_valid;
            dph_write <= next_dph_write;
            dph_addr  <= next_dph_addr;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    logic wr;
    assign wr = dph_valid & dph_write;

    // Configuration registers; out-of-range writes are clamped to the legal span.
    logic [31:0] ctrl, next_ctrl;
    logic [15:0] acc2, next_acc2, dec2, next_dec2;
    logic [23:0] scurve, next_scurve;
    logic [15:0] skip [3], next_skip [3];
    logic [15:0] skip_range, next_skip_range;
    logic [15:0] line_speed, next_line_speed;
    logic [15:0] rated_freq, next_rated_freq;
    logic [9:0]  pid_max, next_pid_max, pid_min, next_pid_min;
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    always_comb begin
        next_ctrl = ctrl;
        next_acc2 = acc2;
        next_dec2 = dec2;
        next_scurve = scurve;
        next_skip = skip;
        next_skip_range = skip_range;
        next_line_speed = line_speed;
        next_rated_freq = rated_freq;
        next_pid_max = pid_max;
        next_pid_min = pid_min;
        if (wr) begin
            case (dph_addr)
                ADDR_CTRL: begin
                    next_ctrl = {9'h000, hwdata[22:0]};
                    if (hwdata[CTRL_CARRIER_LO +: 4] == 4'h0)
                        next_ctrl[CTRL_CARRIER_LO +: 4] = 4'h1;
                    if (hwdata[CTRL_MODE_LO +: 3] > MODE_MAX)
                        next_ctrl[CTRL_MODE_LO +: 3] = MODE_MAX;
                    if (hwdata[CTRL_LINE_LO +: 3] > LINE_MODE_MAX)
                        next_ctrl[CTRL_LINE_LO +: 3] = LINE_MODE_MAX;
                    if (hwdata[CTRL_PIDFMT_LO +: 2] > PID_CODE_MAX)
                        next_ctrl[CTRL_PIDFMT_LO +: 2] = PID_CODE_MAX;
                    if (hwdata[CTRL_PIDUNIT_LO +: 2] > PID_CODE_MAX)
                        next_ctrl[CTRL_PIDUNIT_LO +: 2] = PID_CODE_MAX;
                    next_ctrl[3] = 1'b0;
                end
                ADDR_ACC2:       next_acc2 = clamp16(hwdata[15:0], ACC_MIN, ACC_MAX);
                ADDR_DEC2:       next_dec2 = clamp16(hwdata[15:0], ACC_MIN, ACC_MAX);
                ADDR_SCURVE: begin
                    for (int i = 0; i < 4; i++)
                        next_scurve[i*6 +: 6] = (hwdata[i*8 +: 6] > SCURVE_MAX) ? SCURVE_MAX : hwdata[i*8 +: 6];
                end
                ADDR_SKIP1:      next_skip[0] = clamp16(hwdata[15:0], 16'h0000, FREQ_MAX);
                ADDR_SKIP2:      next_skip[1] = clamp16(hwdata[15:0], 16'h0000, FREQ_MAX);
                ADDR_SKIP3:      next_skip[2] = clamp16(hwdata[15:0], 16'h0000, FREQ_MAX);
                ADDR_SKIP_RANGE: next_skip_range = clamp16(hwdata[15:0], 16'h0000, SKIP_RANGE_MAX);
                ADDR_LINE_SPEED: next_line_speed = hwdata[15:0];
                ADDR_RATED_FREQ: next_rated_freq = clamp16(hwdata[15:0], 16'h0001, FREQ_MAX);
                ADDR_PID_SPAN: begin
                    next_pid_max = (hwdata[9:0] > PID_LIMIT) ? PID_LIMIT : hwdata[9:0];
                    next_pid_min = (hwdata[PID_MIN_LO +: 10] > PID_LIMIT) ? PID_LIMIT : hwdata[PID_MIN_LO +: 10];
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= CTRL_RESET;
            acc2 <= ACC2_RESET;
            dec2 <= DEC2_RESET;
            scurve <= 24'h000000;
            skip <= '{default: 16'h0000};
            skip_range <= 16'h0000;
            line_speed <= LINE_SPEED_RESET;
            rated_freq <= RATED_FREQ_RESET;
            pid_max <= PID_MAX_RESET;
            pid_min <= 10'h000;
        end else begin
            ctrl <= next_ctrl;
            acc2 <= next_acc2;
            dec2 <= next_dec2;
            scurve <= next_scurve;
            skip <= next_skip;
            skip_range <= next_skip_range;
            line_speed <= next_line_speed;
            rated_freq <= next_rated_freq;
            pid_max <= next_pid_max;
            pid_min <= next_pid_min;
        end
    end

    // Run commands and ramp settings.
    assign run_fwd = sync2[0];
    assign run_rev = sync2[1] & ~ctrl[CTRL_REV_BLOCK];
    assign accdec2_active = sync2[2];
    assign ramp_acc_total = acc2 + 16'(scurve[5:0]) + 16'(scurve[11:6]);
    assign ramp_dec_total = dec2 + 16'(scurve[17:12]) + 16'(scurve[23:18]);
    always_comb begin
        for (int i = 0; i < 4; i++)
            scurve_enable[i] = (scurve[i*6 +: 6] != 6'h00);
    end
    assign scurve_ref_freq = rated_freq;

    // Keypad frequency entry and skip bands.
    logic [15:0] edit_freq, next_edit_freq, set_freq, next_set_freq;
    logic [15:0] band_freq;
    always_comb begin
        next_edit_freq = edit_freq;
        next_set_freq  = set_freq;
        if (!view_s && up_press)
            next_edit_freq = (edit_freq > FREQ_MAX - KEY_STEP) ? FREQ_MAX : edit_freq + KEY_STEP;
        else if (!view_s && down_press)
            next_edit_freq = (edit_freq < KEY_STEP) ? 16'h0000 : edit_freq - KEY_STEP;
        if (ctrl[CTRL_UPDN_DIRECT])
            next_set_freq = next_edit_freq;
        else if (enter_press && !view_s)
            next_set_freq = edit_freq;
    end
    always_comb begin
        band_freq = set_freq;
        for (int i = 0; i < 3; i++) begin
            if (skip_range != 16'h0000 && band_freq + skip_range > skip[i] && band_freq < skip[i] + skip_range)
                band_freq = (skip[i] > skip_range) ? skip[i] - skip_range : 16'h0000;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edit_freq <= 16'h0000;
            set_freq  <= 16'h0000;
            freq_out  <= 16'h0000;
        end else begin
            edit_freq <= next_edit_freq;
            set_freq  <= next_set_freq;
            freq_out  <= band_freq;
        end
    end

    // Carrier generation with thermal derating.
    logic        next_derated;
    logic [3:0]  next_khz;
    logic [24:0] acc, next_acc;
    logic [1:0]  third, next_third;
    logic        next_tick;
    always_comb begin
        next_derated = carrier_derated;
        if (!ctrl[CTRL_DERATE_EN])
            next_derated = 1'b0;
        else if (temp_s > TEMP_HOT)
            next_derated = 1'b1;
        else if (temp_s < TEMP_COOL)
            next_derated = 1'b0;
        next_khz = ctrl[CTRL_CARRIER_LO +: 4];
        if (carrier_derated)
            next_khz = (next_khz > DERATE_KHZ) ? next_khz - DERATE_KHZ : 4'h1;
        next_acc   = acc + 25'(carrier_khz) * 25'(KHZ_STEP);
        next_tick  = 1'b0;
        next_third = third;
        if (next_acc >= CLK_HZ_W) begin
            next_acc   = next_acc - CLK_HZ_W;
            next_third = (third == DUAL_DROP) ? 2'h0 : third + 2'h1;
            next_tick  = !(carrier_mode == DAD_DUAL_RANDOM && third == DUAL_DROP);
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            carrier_derated <= 1'b0;
            carrier_khz     <= 4'h1;
            carrier_mode    <= 3'h0;
            acc             <= 25'h0000000;
            third           <= 2'h0;
            carrier_tick    <= 1'b0;
        end else begin
            carrier_derated <= next_derated;
            carrier_khz     <= next_khz;
            carrier_mode    <= ctrl[CTRL_MODE_LO +: 3];
            acc             <= next_acc;
            third           <= next_third;
            carrier_tick    <= next_tick;
        end
    end

    // Display scaling.
    logic [31:0] line_prod;
    logic [15:0] line_val;
    logic [21:0] pid_prod;
    assign line_prod = 32'(freq_out) * 32'(line_speed);
    assign line_val  = 16'(line_prod / 32'(rated_freq));
    assign pid_prod  = (pid_max > pid_min) ? 22'(pid_feedback) * 22'(pid_max - pid_min) : 22'h000000;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            disp_items    <= 5'h00;
            disp_value    <= 16'h0000;
            disp_decimals <= 2'h0;
            pid_disp      <= 10'h000;
            pid_decimals  <= 2'h0;
            pid_unit      <= 2'h0;
        end else begin
            disp_items    <= ctrl[CTRL_DISP_LO +: 5];
            disp_value    <= (ctrl[CTRL_LINE_LO +: 3] == 3'h0) ? freq_out : line_val;
            disp_decimals <= (ctrl[CTRL_LINE_LO +: 3] == 3'h0) ? 2'h2 : 2'(ctrl[CTRL_LINE_LO +: 3] - 3'h1);
            pid_disp      <= pid_min + pid_prod[21:12];
            pid_decimals  <= ctrl[CTRL_PIDFMT_LO +: 2];
            pid_unit      <= ctrl[CTRL_PIDUNIT_LO +: 2];
        end
    end

    // Fault history; a trip in the clearing cycle is kept as the latest entry.
    logic [7:0] flog [3], next_flog [3];
    logic [1:0] next_idx;
    always_comb begin
        next_flog = flog;
        next_idx  = fault_view_idx;
        if (view_s && reset_press)
            next_flog = '{default: 8'h00};
        if (fault_trip) begin
            next_flog[2] = next_flog[1];
            next_flog[1] = next_flog[0];
            next_flog[0] = fault_code;
        end
        if (view_enter)
            next_idx = 2'h0;
        else if (view_s && up_press)
            next_idx = (fault_view_idx == 2'h2) ? 2'h0 : fault_view_idx + 2'h1;
        else if (view_s && down_press)
            next_idx = (fault_view_idx == 2'h0) ? 2'h2 : fault_view_idx - 2'h1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flog <= '{default: 8'h00};
            fault_view_idx <= 2'h0;
        end else begin
            flog <= next_flog;
            fault_view_idx <= next_idx;
        end
    end
    assign fault_view_code = flog[fault_view_idx];

    // Read mux in the data phase.
    always_comb begin
        hrdata = 32'h00000000;
        if (dph_valid && !dph_write) begin
            case (dph_addr)
                ADDR_CTRL:       hrdata = ctrl;
                ADDR_ACC2:       hrdata = {16'h0000, acc2};
                ADDR_DEC2:       hrdata = {16'h0000, dec2};
                ADDR_SCURVE:     hrdata = {2'b00, scurve[23:18], 2'b00, scurve[17:12],
                                           2'b00, scurve[11:6], 2'b00, scurve[5:0]};
                ADDR_SKIP1:      hrdata = {16'h0000, skip[0]};
                ADDR_SKIP2:      hrdata = {16'h0000, skip[1]};
                ADDR_SKIP3:      hrdata = {16'h0000, skip[2]};
                ADDR_SKIP_RANGE: hrdata = {16'h0000, skip_range};
                ADDR_LINE_SPEED: hrdata = {16'h0000, line_speed};
                ADDR_RATED_FREQ: hrdata = {16'h0000, rated_freq};
                ADDR_PID_SPAN:   hrdata = {6'h00, pid_min, 6'h00, pid_max};
                ADDR_STATUS:     hrdata = {8'h00, temp_s, 3'h0, carrier_derated, carrier_khz, freq_out[7:0]};
                ADDR_FAULT_LOG:  hrdata = {8'h00, flog[2], flog[1], flog[0]};
                ADDR_DISPLAY:    hrdata = {freq_out, disp_value};
                default:         hrdata = 32'h00000000;
            endcase
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_rev_block: assert property (ctrl[CTRL_REV_BLOCK] |-> !run_rev) else $error("reverse passed while blocked");
    chk_enter_apply: assert property (!ctrl[CTRL_UPDN_DIRECT] && !enter_press &&
        !$past(ctrl[CTRL_UPDN_DIRECT]) |=> $stable(set_freq)) else $error("frequency applied without enter");
    chk_carrier_range: assert property (carrier_khz >= 4'h1 && carrier_khz <= CARRIER_MAX)
        else $error("carrier out of range");
    chk_derate_set: assert property (ctrl[CTRL_DERATE_EN] && temp_s > TEMP_HOT |=> carrier_derated)
        else $error("hot heatsink not derated");
    chk_derate_clear: assert property (temp_s < TEMP_COOL |=> !carrier_derated)
        else $error("cool heatsink still derated");
    chk_dual_drop: assert property ($past(carrier_mode) == DAD_DUAL_RANDOM && $past(third) == DUAL_DROP &&
        $changed(third) |-> !carrier_tick) else $error("third carrier edge not dropped");
    chk_ramp_sum: assert property (ramp_acc_total >= acc2 && ramp_dec_total >= dec2 &&
        ramp_acc_total - acc2 <= 16'(SCURVE_MAX) * 16'h0002 && ramp_dec_total - dec2 <= 16'(SCURVE_MAX) * 16'h0002)
        else $error("ramp total wrong");
    chk_fault_shift: assert property (fault_trip && !(view_s && reset_press) |=>
        flog[0] == $past(fault_code) && flog[1] == $past(flog[0]) && flog[2] == $past(flog[1]))
        else $error("fault history not shifted");
    chk_fault_clear: assert property (view_s && reset_press && !fault_trip |=>
        flog[0] == 8'h00 && flog[1] == 8'h00 && flog[2] == 8'h00) else $error("fault history not cleared");
    chk_view_wrap: assert property (view_s && !view_enter && up_press && fault_view_idx == 2'h2 |=>
        fault_view_idx == 2'h0) else $error("fault view did not wrap");
    chk_skip_band: assert property (skip_range != 16'h0000 && skip[0] > skip_range && set_freq == skip[0] &&
        skip[1] == skip[0] && skip[2] == skip[0] |=> freq_out != $past(set_freq))
        else $error("frequency inside skip band");
endmodule

// >>> tb/dad_pwm_stage.sv
// Power stage model that counts carrier ticks over a window.
`timescale 1ns/1ns
module dad_pwm_stage (
    // Clock and carrier.
    input  wire logic hclk,
    input  wire logic carrier_tick,
    input  wire logic clr,
    // Tick count since the last clear.
    output int        ticks
);
    always_ff @(posedge hclk) begin
        ticks <= clr ? 0 : ticks + int'(carrier_tick === 1'b1);
    end
endmodule

// >>> tb/drive_assist_display_log_tb.sv
// Testbench of the drive assist, display and fault log block.
`timescale 1ns/1ns
module drive_assist_display_log_tb;
    import dad_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rev = 0, mfi = 0, fview = 0, trip = 0, clr = 0;
    logic [1:0]  htrans = 0;
    logic [3:0]  keys = 0;
    logic [7:0]  temp = 0, fcode = 0, vcode;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic        hready, run_rev, acc2, derated, tick, fwd;
    logic [15:0] freq_out, acc_t, dec_t, disp_value, rfreq;
    logic [3:0]  khz, s_en;
    logic [1:0]  vidx, ddec, pdec, punit;
    logic [2:0]  cmode;
    logic [4:0]  ditems;
    logic [9:0]  pdisp;
    logic [11:0] pidfb = 0;
    int          err_total = 0, checked = 0, cycles = 0, ticks;
    dad_top dad_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hreadyout(hready), .hresp(), .hrdata, .run_fwd_pin(rev), .run_rev_pin(rev),
        .multifunction_input_select(mfi), .key_up(keys[0]), .key_down(keys[1]), .key_enter(keys[2]),
        .key_reset(keys[3]), .fault_view(fview), .heatsink_temp(temp), .pid_feedback(pidfb), .fault_trip(trip),
        .fault_code(fcode), .run_fwd(fwd), .run_rev, .freq_out, .accdec2_active(acc2), .ramp_acc_total(acc_t),
        .ramp_dec_total(dec_t), .scurve_enable(s_en), .scurve_ref_freq(rfreq), .carrier_khz(khz), .carrier_mode(cmode),
        .carrier_tick(tick), .carrier_derated(derated), .disp_items(ditems), .disp_value, .disp_decimals(ddec),
        .pid_disp(pdisp), .pid_decimals(pdec), .pid_unit(punit), .fault_view_idx(vidx), .fault_view_code(vcode));
    dad_pwm_stage dad_pwm_stage_i (.hclk, .carrier_tick(tick), .clr, .ticks);
    initial forever #20 hclk = ~hclk;
    task automatic close_out;
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %0t mismatch seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Called just after a rising edge; holds each phase until hready is seen high.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic press(input int k);
        keys[k] <= 1; wt(4); keys[k] <= 0; wt(4);
    endtask
    task automatic t_reset;
        bus(0, ADDR_CTRL, 0); chk(rd, CTRL_RESET);
        chk(khz, 4'h5);
        chk(acc_t, ACC2_RESET);
    endtask
    task automatic t_rev;
        rev <= 1; wt(4); chk(run_rev, 1);
        bus(1, ADDR_CTRL, 32'h51); wt(2); chk(run_rev, 0); chk(fwd, 1);
        rev <= 0;
    endtask
    task automatic t_ramp;
        bus(1, ADDR_ACC2, 32'h32); bus(1, ADDR_DEC2, 32'h8CA0); bus(1, ADDR_SCURVE, 32'h00280A00); wt(1);
        chk(acc_t, 16'h3C); chk(dec_t, 16'h8CC8);
        chk(s_en, 4'h6);
        mfi <= 1; wt(4); chk(acc2, 1);
    endtask
    task automatic t_key;
        press(0); chk(freq_out, 0);
        press(2); chk(freq_out, 16'hA);
        bus(1, ADDR_CTRL, 32'h10052); press(0); press(0); chk(freq_out, 16'h1E);
        wt(2); chk(disp_value, 16'h9);
    endtask
    task automatic t_fault;
        for (int i = 1; i <= 3; i++) begin
            trip <= 1; fcode <= 8'(i * 17); wt(1); trip <= 0; wt(1);
        end
        bus(0, ADDR_FAULT_LOG, 0); chk(rd, 32'h112233);
        fview <= 1; wt(4); chk(vcode, 8'h33);
        press(0); chk(vcode, 8'h22);
        press(1); press(1); chk(vidx, 2'h2);
        press(3); bus(0, ADDR_FAULT_LOG, 0); chk(rd, 0);
        fview <= 0;
    endtask
    task automatic t_disp;
        pidfb <= 12'h800; bus(1, ADDR_PID_SPAN, 32'h00320064); bus(1, ADDR_CTRL, 32'h4B8F00); wt(2);
        chk(cmode, DAD_DUAL_RANDOM); chk(khz, 4'h1);
        chk(ditems, 5'h11); chk(ddec, 2'h2); chk(disp_value, 16'h9);
        chk(pdisp, 10'h04B); chk(pdec, 2'h1); chk(punit, 2'h2);
        chk(rfreq, RATED_FREQ_RESET);
        bus(1, ADDR_SKIP1, 32'h1E); bus(1, ADDR_SKIP2, 32'h1E); bus(1, ADDR_SKIP3, 32'h1E);
        bus(1, ADDR_SKIP_RANGE, 32'h14); wt(2); chk(freq_out, 16'hA);
    endtask
    task automatic t_derate;
        bus(1, ADDR_CTRL, 32'hA4); clr <= 1; wt(1); clr <= 0; wt(25000); chk(ticks >= 9 && ticks <= 11, 1);
        bus(1, ADDR_CTRL, 32'h4A4); clr <= 1; wt(1); clr <= 0; wt(25000); chk(ticks >= 6 && ticks <= 7, 1);
        temp <= 8'h51; wt(6); chk(khz, 4'h6); chk(derated, 1);
        temp <= 8'h4B; wt(6); chk(khz, 4'h6);
        temp <= 8'h45; wt(6); chk(khz, 4'hA);
    endtask
    initial begin
        wt(16); hresetn <= 1; wt(1);
        t_reset(); t_rev(); t_ramp(); t_key(); t_fault(); t_disp(); t_derate();
        close_out();
    end
endmodule
